//--- dpx_regs.svh
// Purpose: constants of the dual pointer and extended opcode block
// Assumes: included by its bare name from the core and the testbench
// Notes: offsets are byte addresses of the register port
// Contract
// [RL1] redirect bit steers pointer-one moves to B
// [RL2] select bit swaps primary and alternate pointer
// [RL3] index disable drops accumulator from code fetch
// [RL4] code fetch index stays the accumulator
// [RL5] separate circular enables for both pointers
// [RL6] buffer length from end register E3H
// [RL7] buffers 0000H..end and 0100H..100H+end
// [RL8] increment at buffer end wraps to start
// [RL9] decrement at buffer start wraps to end
// [RL10] wrapping for explicit and automatic updates
// [RL11] elsewhere pointers step as plain 16-bit
// [RL12] either pointer runs in either buffer
// [RL13] software clears modes around flash calls
// [RL14] auto update post steps by direction bit
// [RL15] A5 00 is breakpoint, 2 cycles
// [RL16] A5 03 shifts right, A5 E4 clears
// [RL17] A5 23 shifts accumulate register left
// [RL18] A5 73 jumps to PC plus A
// [RL19] A5 90 loads alternate pointer, 4 bytes
// [RL20] A5 93 fetches code at alternate plus A
// [RL21] A5 A3 increments alternate pointer, 3 cycles
// [RL22] A5 A4 multiply accumulate, 9 cycles
// [RL23] A5 B6/B7 compare indirect, branch if differ
// [RL24] A5 E0/F0 external move via alternate pointer
// [RL25] boundary compare uses full 16-bit value
`ifndef DPX_REGS_SVH
`define DPX_REGS_SVH
// register offsets
`define DPX_ADDR_CFG 8'hE1
`define DPX_ADDR_MODE 8'hE2
`define DPX_ADDR_END 8'hE3
`define DPX_ADDR_P0L 8'hE4
`define DPX_ADDR_P0H 8'hE5
`define DPX_ADDR_P1L 8'hE6
`define DPX_ADDR_P1H 8'hE7
// mode register fields
`define DPX_MODE_REDIR 0
`define DPX_MODE_NOIDX 1
`define DPX_MODE_CIRC0 2
`define DPX_MODE_CIRC1 3
// config register fields
`define DPX_CFG_SEL 0
`define DPX_CFG_DEC0 4
`define DPX_CFG_DEC1 5
`define DPX_CFG_UPD0 6
`define DPX_CFG_UPD1 7
`define DPX_RST_BYTE 8'h00
// buffer region bases, high byte
`define DPX_BUF_A_HI 8'h00
`define DPX_BUF_B_HI 8'h01
// extended opcodes, byte after the prefix
`define DPX_OPC_BREAK 8'h00
`define DPX_OPC_ASR 8'h03
`define DPX_OPC_LSL 8'h23
`define DPX_OPC_JMP 8'h73
`define DPX_OPC_LDP 8'h90
`define DPX_OPC_MOVC 8'h93
`define DPX_OPC_INC 8'hA3
`define DPX_OPC_MAC 8'hA4
`define DPX_OPC_CJ0 8'hB6
`define DPX_OPC_CJ1 8'hB7
`define DPX_OPC_XRD 8'hE0
`define DPX_OPC_CLR 8'hE4
`define DPX_OPC_XWR 8'hF0
`endif

//--- dpx_pkg.sv
// Purpose: types of the dual pointer and extended opcode block
// Assumes: nothing
// Notes: used by full scoped names only
package dpx_pkg;
  // pointer access kinds from the sequencer
  typedef enum logic [2:0] {
    DPX_ACC_XRD = 3'h0,
    DPX_ACC_XWR = 3'h1,
    DPX_ACC_CODE = 3'h2,
    DPX_ACC_INC = 3'h3,
    DPX_ACC_LOAD = 3'h4
  } dpx_acc_t;
  // extended operation classes
  typedef enum logic [3:0] {
    DPX_OP_BREAK = 4'h0,
    DPX_OP_ASR = 4'h1,
    DPX_OP_LSL = 4'h2,
    DPX_OP_JMP = 4'h3,
    DPX_OP_LDP = 4'h4,
    DPX_OP_MOVC = 4'h5,
    DPX_OP_INC = 4'h6,
    DPX_OP_MAC = 4'h7,
    DPX_OP_CJNE = 4'h8,
    DPX_OP_XRD = 4'h9,
    DPX_OP_CLR = 4'hA,
    DPX_OP_XWR = 4'hB,
    DPX_OP_UNDEF = 4'hF
  } dpx_op_t;
  // decode answer
  typedef struct packed {
    logic valid;
    dpx_op_t op;
    logic [2:0] bytes;
    logic [3:0] cycles;
    logic use_alt;
    logic use_r1;
    logic taken;
    logic [15:0] target;
  } dpx_dec_t;
  // memory access answer
  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic use_b;
    logic write;
  } dpx_mem_t;
  // whole state of the core
  typedef struct packed {
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [7:0] mode;
    logic [7:0] cfg;
    logic [7:0] bend;
    logic [7:0] rdata;
    dpx_mem_t mem;
    dpx_dec_t dec;
  } dpx_state_t;
endpackage

//--- dpx_core.sv
// Purpose: data pointer modes and prefixed opcode decode
// Assumes: sequencer presents one access and one decode at a time
// Notes: answers appear one cycle after the request
`include "dpx_regs.svh"
module dpx_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [7:0] reg_rdata_o,
  // pointer access request
  input wire logic acc_valid_i,
  input wire dpx_pkg::dpx_acc_t acc_kind_i,
  input wire logic acc_alt_i,
  input wire logic [15:0] acc_load_i,
  // core operands
  input wire logic [7:0] a_i,
  input wire logic [15:0] pc_i,
  input wire logic [7:0] ind_ram_i,
  // extended decode request
  input wire logic dec_valid_i,
  input wire logic [7:0] dec_opc_i,
  input wire logic xmem_slow_i,
  // answers
  output dpx_pkg::dpx_mem_t mem_o,
  output dpx_pkg::dpx_dec_t dec_o,
  output logic [15:0] ptr0_o,
  output logic [15:0] ptr1_o
);
  // registered state and its next copy
  dpx_pkg::dpx_state_t s_reg;
  dpx_pkg::dpx_state_t s_next;
  // effective pointer of the current access
  logic eff_idx;
  logic [15:0] eff_ptr;
  logic eff_circ;
  logic eff_dn;
  logic eff_upd;
  logic [15:0] stepped;

  // one pointer step with circular wrapping
  function automatic logic [15:0] dpx_step(
    input logic [15:0] p,
    input logic dn,
    input logic circ,
    input logic [7:0] e
  );
    logic [15:0] r;
    r = dn ? 16'(p - 16'h0001) : 16'(p + 16'h0001); // [RL11]
    if (circ) begin
      // full 16-bit compare against the limits
      if (!dn && p == {`DPX_BUF_A_HI, e}) begin // [RL25]
        r = {`DPX_BUF_A_HI, 8'h00}; // [RL8]
      end else if (!dn && p == {`DPX_BUF_B_HI, e}) begin
        r = {`DPX_BUF_B_HI, 8'h00}; // [RL8]
      end else if (dn && p == {`DPX_BUF_A_HI, 8'h00}) begin
        r = {`DPX_BUF_A_HI, e}; // [RL9]
      end else if (dn && p == {`DPX_BUF_B_HI, 8'h00}) begin
        r = {`DPX_BUF_B_HI, e}; // [RL9]
      end
    end
    return r;
  endfunction

  // pick the pointer that the access references
  always_comb begin
    eff_idx = acc_alt_i ^ s_reg.cfg[`DPX_CFG_SEL]; // [RL2]
    eff_ptr = eff_idx ? s_reg.ptr1 : s_reg.ptr0;
    // per-pointer enables, same rules for both buffers
    eff_circ = eff_idx ? s_reg.mode[`DPX_MODE_CIRC1]
                       : s_reg.mode[`DPX_MODE_CIRC0]; // [RL5] [RL12]
    eff_dn = eff_idx ? s_reg.cfg[`DPX_CFG_DEC1]
                     : s_reg.cfg[`DPX_CFG_DEC0];
    eff_upd = eff_idx ? s_reg.cfg[`DPX_CFG_UPD1]
                      : s_reg.cfg[`DPX_CFG_UPD0];
    stepped = dpx_step(eff_ptr, eff_dn, eff_circ, s_reg.bend); // [RL6]
  end

  // next state
  always_comb begin
    logic upd;
    logic [15:0] newp;
    s_next = s_reg;
    upd = 1'b0;
    newp = eff_ptr;
    // single-cycle answers drop by default
    s_next.mem.valid = 1'b0;
    s_next.dec = '0;
    s_next.rdata = 8'h00;
    // pointer accesses
    if (acc_valid_i) begin
      unique case (acc_kind_i)
        dpx_pkg::DPX_ACC_XRD, dpx_pkg::DPX_ACC_XWR: begin
          s_next.mem.valid = 1'b1;
          s_next.mem.addr = eff_ptr;
          s_next.mem.write = (acc_kind_i == dpx_pkg::DPX_ACC_XWR);
          // pointer one moves through B when redirected
          s_next.mem.use_b = eff_idx &
            s_reg.mode[`DPX_MODE_REDIR]; // [RL1]
          upd = eff_upd; // [RL14]
          newp = stepped; // [RL10]
        end
        dpx_pkg::DPX_ACC_CODE: begin
          s_next.mem.valid = 1'b1;
          s_next.mem.write = 1'b0;
          // index is A unless index disable is set, only the pointer moves
          s_next.mem.addr = s_reg.mode[`DPX_MODE_NOIDX] ? eff_ptr
            : 16'(eff_ptr + {8'h00, a_i}); // [RL3] [RL4]
          s_next.mem.use_b = eff_idx &
            s_reg.mode[`DPX_MODE_REDIR]; // [RL1]
          upd = eff_upd; // [RL14]
          newp = stepped; // [RL10]
        end
        dpx_pkg::DPX_ACC_INC: begin
          // explicit step follows the direction bit too
          upd = 1'b1;
          newp = stepped; // [RL10]
        end
        dpx_pkg::DPX_ACC_LOAD: begin
          upd = 1'b1;
          newp = acc_load_i; // [RL19]
        end
        default: begin
          upd = 1'b0;
        end
      endcase
    end
    if (upd) begin
      if (eff_idx) begin
        s_next.ptr1 = newp;
      end else begin
        s_next.ptr0 = newp;
      end
    end
    // register writes win over a same-cycle access
    if (reg_we_i) begin
      unique case (reg_addr_i)
        `DPX_ADDR_CFG: s_next.cfg = reg_wdata_i;
        `DPX_ADDR_MODE: s_next.mode = reg_wdata_i;
        `DPX_ADDR_END: s_next.bend = reg_wdata_i; // [RL6]
        `DPX_ADDR_P0L: s_next.ptr0[7:0] = reg_wdata_i;
        `DPX_ADDR_P0H: s_next.ptr0[15:8] = reg_wdata_i;
        `DPX_ADDR_P1L: s_next.ptr1[7:0] = reg_wdata_i;
        `DPX_ADDR_P1H: s_next.ptr1[15:8] = reg_wdata_i;
        default: begin
        end
      endcase
    end
    // reads answer next cycle, unmapped reads give zero
    if (reg_re_i) begin
      unique case (reg_addr_i)
        `DPX_ADDR_CFG: s_next.rdata = s_reg.cfg;
        `DPX_ADDR_MODE: s_next.rdata = s_reg.mode;
        `DPX_ADDR_END: s_next.rdata = s_reg.bend;
        `DPX_ADDR_P0L: s_next.rdata = s_reg.ptr0[7:0];
        `DPX_ADDR_P0H: s_next.rdata = s_reg.ptr0[15:8];
        `DPX_ADDR_P1L: s_next.rdata = s_reg.ptr1[7:0];
        `DPX_ADDR_P1H: s_next.rdata = s_reg.ptr1[15:8];
        default: s_next.rdata = 8'h00;
      endcase
    end
    // prefixed opcode decode
    if (dec_valid_i) begin
      s_next.dec.valid = 1'b1;
      s_next.dec.bytes = 3'h2;
      unique case (dec_opc_i)
        `DPX_OPC_BREAK: begin
          s_next.dec.op = dpx_pkg::DPX_OP_BREAK; // [RL15]
          s_next.dec.cycles = 4'h2;
        end
        `DPX_OPC_ASR: begin
          s_next.dec.op = dpx_pkg::DPX_OP_ASR; // [RL16]
          s_next.dec.cycles = 4'h2;
        end
        `DPX_OPC_CLR: begin
          s_next.dec.op = dpx_pkg::DPX_OP_CLR; // [RL16]
          s_next.dec.cycles = 4'h2;
        end
        `DPX_OPC_LSL: begin
          s_next.dec.op = dpx_pkg::DPX_OP_LSL; // [RL17]
          s_next.dec.cycles = 4'h2;
        end
        `DPX_OPC_JMP: begin
          s_next.dec.op = dpx_pkg::DPX_OP_JMP;
          s_next.dec.cycles = 4'h3;
          s_next.dec.target = 16'(pc_i + {8'h00, a_i}); // [RL18]
        end
        `DPX_OPC_LDP: begin
          s_next.dec.op = dpx_pkg::DPX_OP_LDP; // [RL19]
          s_next.dec.bytes = 3'h4;
          s_next.dec.cycles = 4'h4;
          s_next.dec.use_alt = 1'b1;
        end
        `DPX_OPC_MOVC: begin
          s_next.dec.op = dpx_pkg::DPX_OP_MOVC; // [RL20]
          s_next.dec.cycles = 4'h4;
          s_next.dec.use_alt = 1'b1;
        end
        `DPX_OPC_INC: begin
          s_next.dec.op = dpx_pkg::DPX_OP_INC; // [RL21]
          s_next.dec.cycles = 4'h3;
          s_next.dec.use_alt = 1'b1;
        end
        `DPX_OPC_MAC: begin
          s_next.dec.op = dpx_pkg::DPX_OP_MAC; // [RL22]
          s_next.dec.cycles = 4'h9;
        end
        `DPX_OPC_CJ0, `DPX_OPC_CJ1: begin
          s_next.dec.op = dpx_pkg::DPX_OP_CJNE; // [RL23]
          s_next.dec.bytes = 3'h3;
          s_next.dec.cycles = 4'h4;
          s_next.dec.use_r1 = dec_opc_i[0];
          s_next.dec.taken = (a_i != ind_ram_i);
        end
        `DPX_OPC_XRD, `DPX_OPC_XWR: begin
          s_next.dec.op = (dec_opc_i == `DPX_OPC_XRD)
            ? dpx_pkg::DPX_OP_XRD : dpx_pkg::DPX_OP_XWR;
          s_next.dec.cycles = xmem_slow_i ? 4'h5 : 4'h3; // [RL24]
          s_next.dec.use_alt = 1'b1;
        end
        default: begin
          // unknown second byte: prefix taken as one-byte no-op
          s_next.dec.op = dpx_pkg::DPX_OP_UNDEF;
          s_next.dec.bytes = 3'h1;
          s_next.dec.cycles = 4'h1;
        end
      endcase
    end
  end

  // state register, modes off after reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // outputs straight from flops
  assign reg_rdata_o = s_reg.rdata;
  assign mem_o = s_reg.mem;
  assign dec_o = s_reg.dec;
  assign ptr0_o = s_reg.ptr0;
  assign ptr1_o = s_reg.ptr1;

  // checks
  logic step_up;
  logic step_dn;
  assign step_up = acc_valid_i && acc_kind_i == dpx_pkg::DPX_ACC_INC
    && eff_circ && !eff_dn && !reg_we_i;
  assign step_dn = acc_valid_i && acc_kind_i == dpx_pkg::DPX_ACC_INC
    && eff_circ && eff_dn && !reg_we_i;

  a_wrap_inc_a: assert property (@(posedge clk_i) disable iff (rst_i)
    step_up && eff_ptr == {8'h00, s_reg.bend} && !eff_idx
    |=> s_reg.ptr0 == 16'h0000) // [RL8]
    else $error("pointer zero did not wrap to 0000H");
  a_wrap_inc_b: assert property (@(posedge clk_i) disable iff (rst_i)
    step_up && eff_ptr == {8'h01, s_reg.bend} && eff_idx
    |=> s_reg.ptr1 == 16'h0100) // [RL8]
    else $error("pointer one did not wrap to 0100H");
  a_wrap_dec_b: assert property (@(posedge clk_i) disable iff (rst_i)
    step_dn && eff_ptr == 16'h0100 && !eff_idx
    |=> s_reg.ptr0 == {8'h01, $past(s_reg.bend)}) // [RL9]
    else $error("decrement at 0100H did not wrap");
  a_plain_step: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_i && acc_kind_i == dpx_pkg::DPX_ACC_INC && !eff_circ
    && !eff_dn && !eff_idx && !reg_we_i
    |=> s_reg.ptr0 == 16'($past(s_reg.ptr0) + 16'h0001)) // [RL11]
    else $error("plain increment wrong");
  a_redir_b: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_i && acc_kind_i == dpx_pkg::DPX_ACC_XRD
    |=> mem_o.valid && mem_o.use_b ==
      ($past(eff_idx) && $past(s_reg.mode[`DPX_MODE_REDIR]))) // [RL1]
    else $error("redirect to B wrong");
  a_code_index: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_i && acc_kind_i == dpx_pkg::DPX_ACC_CODE
    |=> mem_o.addr == ($past(s_reg.mode[`DPX_MODE_NOIDX])
      ? $past(eff_ptr)
      : 16'($past(eff_ptr) + {8'h00, $past(a_i)}))) // [RL3]
    else $error("code fetch address wrong");
  a_sel_swap: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_i && acc_kind_i == dpx_pkg::DPX_ACC_XRD
    |=> mem_o.addr == (($past(acc_alt_i) ^ $past(s_reg.cfg[0]))
      ? $past(s_reg.ptr1) : $past(s_reg.ptr0))) // [RL2]
    else $error("pointer select wrong");
  a_mac_cycles: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i && dec_opc_i == `DPX_OPC_MAC
    |=> dec_o.valid && dec_o.cycles == 4'h9) // [RL22]
    else $error("multiply accumulate cycles wrong");
  a_jmp_target: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i && dec_opc_i == `DPX_OPC_JMP
    |=> dec_o.target == 16'($past(pc_i) + {8'h00, $past(a_i)})
      && dec_o.cycles == 4'h3) // [RL18]
    else $error("table jump target wrong");
  a_cjne_taken: assert property (@(posedge clk_i) disable iff (rst_i)
    dec_valid_i && dec_opc_i == `DPX_OPC_CJ1
    |=> dec_o.bytes == 3'h3 && dec_o.use_r1
      && dec_o.taken == ($past(a_i) != $past(ind_ram_i))) // [RL23]
    else $error("compare branch decode wrong");
  a_auto_upd: assert property (@(posedge clk_i) disable iff (rst_i)
    acc_valid_i && acc_kind_i == dpx_pkg::DPX_ACC_XWR && !eff_upd
    && !reg_we_i |=> $stable(s_reg.ptr0) && $stable(s_reg.ptr1)) // [RL14]
    else $error("pointer moved without auto update");

  c_wrap_up: cover property (@(posedge clk_i) disable iff (rst_i)
    step_up && eff_ptr == {8'h01, s_reg.bend});
  c_wrap_dn: cover property (@(posedge clk_i) disable iff (rst_i)
    step_dn && eff_ptr == 16'h0000);
  c_redir: cover property (@(posedge clk_i) disable iff (rst_i)
    mem_o.valid && mem_o.use_b);
  c_cjne: cover property (@(posedge clk_i) disable iff (rst_i)
    dec_o.valid && dec_o.op == dpx_pkg::DPX_OP_CJNE && dec_o.taken);
endmodule

//--- dpx_seq_model.sv
// Purpose: sequencer model that issues pointer accesses and decodes
// Assumes: requests change just after a rising edge, one at a time
// Notes: released operands turn inverted so stale values never match
module dpx_seq_model (
  // clock
  input wire logic clk_i,
  // pointer access request
  output logic acc_valid_o,
  output dpx_pkg::dpx_acc_t acc_kind_o,
  output logic acc_alt_o,
  output logic [15:0] acc_load_o,
  // core operands
  output logic [7:0] a_o,
  output logic [15:0] pc_o,
  output logic [7:0] ind_ram_o,
  // decode request
  output logic dec_valid_o,
  output logic [7:0] dec_opc_o,
  output logic xmem_slow_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // idle values at time zero
  initial begin
    acc_valid_o = 1'b0;
    acc_kind_o = dpx_pkg::DPX_ACC_XRD;
    acc_alt_o = 1'b0;
    acc_load_o = 16'h0000;
    a_o = 8'h00;
    pc_o = 16'h0000;
    ind_ram_o = 8'h00;
    dec_valid_o = 1'b0;
    dec_opc_o = 8'h00;
    xmem_slow_o = 1'b0;
  end
  // one pointer access, answer settles just after the next edge
  task automatic access(input dpx_pkg::dpx_acc_t k, input logic alt,
                        input logic [7:0] a, input logic [15:0] ld);
    @(posedge clk_i);
    acc_valid_o <= 1'b1;
    acc_kind_o <= k;
    acc_alt_o <= alt;
    a_o <= a;
    acc_load_o <= ld;
    @(posedge clk_i);
    acc_valid_o <= 1'b0;
    a_o <= ~a;
    acc_load_o <= ~ld;
    #1;
  endtask
  // one decode of the byte after the prefix
  task automatic decode(input logic [7:0] opc, input logic slow,
                        input logic [7:0] a, input logic [7:0] ram);
    @(posedge clk_i);
    dec_valid_o <= 1'b1;
    dec_opc_o <= opc;
    xmem_slow_o <= slow;
    a_o <= a;
    pc_o <= 16'h1000;
    ind_ram_o <= ram;
    @(posedge clk_i);
    dec_valid_o <= 1'b0;
    dec_opc_o <= ~opc;
    a_o <= ~a;
    pc_o <= 16'hEFFF;
    ind_ram_o <= ~ram;
    #1;
  endtask
endmodule

//--- testbench.sv
// Purpose: self-checking bench for the dual pointer and decode block
// Assumes: register port and sequencer model follow the core contract
// Notes: expectations are worked out here from pointer arithmetic
`include "dpx_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // clock, reset and register port
  logic clk_i;
  logic rst_i;
  logic [7:0] reg_addr_i;
  logic [7:0] reg_wdata_i;
  logic reg_we_i;
  logic reg_re_i;
  logic [7:0] reg_rdata_o;
  // sequencer side
  logic acc_valid_i;
  dpx_pkg::dpx_acc_t acc_kind_i;
  logic acc_alt_i;
  logic [15:0] acc_load_i;
  logic [7:0] a_i;
  logic [15:0] pc_i;
  logic [7:0] ind_ram_i;
  logic dec_valid_i;
  logic [7:0] dec_opc_i;
  logic xmem_slow_i;
  // answers
  dpx_pkg::dpx_mem_t mem_o;
  dpx_pkg::dpx_dec_t dec_o;
  logic [15:0] ptr0_o;
  logic [15:0] ptr1_o;
  // bookkeeping
  int errors;
  int samples_checked;
  int cycles;
  logic [15:0] starts [8];
  logic [19:0] dtab [14];
  dpx_core uut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_we_i,
    .reg_re_i, .reg_rdata_o, .acc_valid_i, .acc_kind_i, .acc_alt_i,
    .acc_load_i, .a_i, .pc_i, .ind_ram_i, .dec_valid_i, .dec_opc_i,
    .xmem_slow_i, .mem_o, .dec_o, .ptr0_o, .ptr1_o);
  dpx_seq_model seq (.clk_i, .acc_valid_o(acc_valid_i),
    .acc_kind_o(acc_kind_i), .acc_alt_o(acc_alt_i),
    .acc_load_o(acc_load_i), .a_o(a_i), .pc_o(pc_i),
    .ind_ram_o(ind_ram_i), .dec_valid_o(dec_valid_i),
    .dec_opc_o(dec_opc_i), .xmem_slow_o(xmem_slow_i));
  // 40 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      wrap_up();
    end
  end
  // counts and verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // compare and report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // register write, one strobe cycle then a gap
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= ad;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  // register read, data looked at in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= ad;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1;
    chk({8'h00, reg_rdata_o}, {8'h00, exp});
  endtask
  // pointer load through low and high byte registers
  task automatic wp(input logic pn, input logic [15:0] v);
    wr(pn ? `DPX_ADDR_P1L : `DPX_ADDR_P0L, v[7:0]);
    wr(pn ? `DPX_ADDR_P1H : `DPX_ADDR_P0H, v[15:8]);
  endtask
  // expected pointer after one step, wrap only at exact limits
  function automatic logic [15:0] step(input logic [15:0] p,
      input logic dn, input logic circ, input logic [7:0] e);
    if (circ && !dn && p == {8'h00, e}) return 16'h0000;
    if (circ && !dn && p == {8'h01, e}) return 16'h0100;
    if (circ && dn && p == 16'h0000) return {8'h00, e};
    if (circ && dn && p == 16'h0100) return {8'h01, e};
    return dn ? p - 16'h0001 : p + 16'h0001;
  endfunction
  // main sequence
  initial begin
    logic pn;
    logic [15:0] pv;
    logic [3:0] cy;
    rst_i = 1'b1;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    reg_we_i = 1'b0;
    reg_re_i = 1'b0;
    starts = '{16'h0005, 16'h0000, 16'h0105, 16'h0100, 16'h0006,
               16'h00FF, 16'h0205, 16'h0200};
    // opcode, op class, bytes, cycles
    dtab = '{20'h00022, 20'h03122, 20'h23222, 20'h73323, 20'h90444,
             20'h93524, 20'hA3623, 20'hA4729, 20'hB6834, 20'hB7834,
             20'hE0923, 20'hE4A22, 20'hF0B23, 20'h01F11};
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    // reset values and an unmapped place
    rd(`DPX_ADDR_CFG, 8'h00);
    rd(`DPX_ADDR_MODE, 8'h00);
    rd(`DPX_ADDR_END, 8'h00);
    wr(`DPX_ADDR_END, 8'hFF);
    rd(`DPX_ADDR_END, 8'hFF);
    rd(8'hE0, 8'h00);
    $display("test registers done");
    // every select, redirect, index-disable and pointer naming
    wp(1'b0, 16'h1234);
    wp(1'b1, 16'h5678);
    for (int i = 0; i < 16; i++) begin
      wr(`DPX_ADDR_CFG, {7'h00, i[0]});
      wr(`DPX_ADDR_MODE, {6'h00, i[2], i[1]});
      pn = i[0] ^ i[3];
      pv = pn ? 16'h5678 : 16'h1234;
      seq.access(i[0] ? dpx_pkg::DPX_ACC_XWR : dpx_pkg::DPX_ACC_XRD,
                 i[3], 8'h10, 16'h0000);
      chk({mem_o.valid, mem_o.write, mem_o.addr[13:0]},
          {1'b1, i[0], pv[13:0]});
      chk({15'h0000, mem_o.use_b}, {15'h0000, i[1] & pn});
      seq.access(dpx_pkg::DPX_ACC_CODE, i[3], 8'h10, 16'h0000);
      chk(mem_o.addr, i[2] ? pv : pv + 16'h0010);
      chk({15'h0000, mem_o.use_b}, {15'h0000, i[1] & pn});
    end
    $display("test pointer modes done");
    // circular stepping, explicit and automatic, both pointers
    wr(`DPX_ADDR_END, 8'h05);
    for (int i = 0; i < 128; i++) begin
      pn = i[0];
      pv = starts[i[6:4]];
      wr(`DPX_ADDR_MODE, {4'h0, i[2] & pn, i[2] & !pn, 2'b00});
      wr(`DPX_ADDR_CFG, {i[3] & pn, i[3] & !pn, i[1] & pn,
                         i[1] & !pn, 4'h0});
      wp(pn, pv);
      seq.access(i[3] ? dpx_pkg::DPX_ACC_XRD : dpx_pkg::DPX_ACC_INC,
                 pn, 8'h00, 16'h0000);
      if (i[3]) chk(mem_o.addr, pv);
      chk(pn ? ptr1_o : ptr0_o,
          step(pv, i[1], i[2], 8'h05));
    end
    $display("test circular done");
    // alternate pointer load with the selection swapped
    wr(`DPX_ADDR_MODE, 8'h00);
    wr(`DPX_ADDR_CFG, 8'h01);
    seq.access(dpx_pkg::DPX_ACC_LOAD, 1'b1, 8'h00, 16'hBEEF);
    chk(ptr0_o, 16'hBEEF);
    wr(`DPX_ADDR_CFG, 8'h00);
    $display("test load done");
    // every prefixed opcode, fast and slow external timing
    for (int i = 0; i < 28; i++) begin
      seq.decode(dtab[i / 2][19:12], i[0], 8'h21, i[0] ? 8'h21 : 8'h22);
      cy = dtab[i / 2][3:0];
      if (i[0] && (dtab[i / 2][11:8] == 4'h9 || dtab[i / 2][11:8] == 4'hB))
        cy = 4'h5;
      chk({dec_o.valid, 3'h0, dec_o.op, 1'b0, dec_o.bytes, dec_o.cycles},
          {1'b1, 3'h0, dtab[i / 2][11:4], cy});
      if (dtab[i / 2][11:8] == 4'h8)
        chk({14'h0000, dec_o.taken, dec_o.use_r1},
            {14'h0000, !i[0], dtab[i / 2][12]});
      if (dtab[i / 2][11:8] == 4'h3) chk(dec_o.target, 16'h1021);
    end
    $display("test decode done");
    wrap_up();
  end
endmodule
